/* File: hdl/bppm_regs.sv */
// Bus power path monitor: control/status registers, serial agent, gating and discharge timer
`timescale 1ns/1ps

module bppm_regs
	import bppm_pkg::*;
#(
	parameter int         UNIT_CYC = DISCH_UNIT_CYC,
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	// Clock and pin reset
	input  wire logic      clk_i,
	input  wire logic      arst_n_i,
	// Serial register port, open drain data
	input  wire logic      scl_i,
	input  wire logic      sda_i,
	output logic           sda_o,
	output logic           sda_oe_n_o,
	// Nonvolatile defaults
	input  wire bppm_nvm_t nvm_i,
	// Analog comparators and attach machine
	input  wire bppm_cmp_t cmp_i,
	input  wire logic      attach_req_i,
	input  wire logic      discharge_start_i,
	// Outputs to the rest of the device
	output logic           core_hold_o,
	output logic [1:0]     bus_safe_zero_level_sel_o,
	output logic           bus_valid_o,
	output logic           attach_safe0_ok_o,
	output logic           discharge_active_flag_o,
	output logic           source_path_enable_pin_o
);

	if (UNIT_CYC < 3 || UNIT_CYC >= (1 << UNIT_CNT_W)) begin : g_unit_check
		$error("UNIT_CYC out of range for the unit counter");
	end

	// ========================================================================
	// Control and status registers, comparator capture and discharge timer
	logic        hold_q;
	logic [3:0]  coeff_q;
	logic        ov_off_q;
	logic        win_off_q;
	logic [1:0]  safe0_q;
	logic        uv_off_q;
	logic        load_q;
	bppm_cmp_t   cmp_q;
	logic        disch_q;
	logic        src_q;
	logic [UNIT_CNT_W-1:0] unit_q;
	logic [3:0]  left_q;

	// Serial agent
	bppm_state_t state_q;
	logic        scl_q;
	logic        sda_q;
	logic [7:0]  shreg_q;
	logic [3:0]  bitcnt_q;
	logic [1:0]  byte_idx_q;
	logic        rw_q;
	logic [7:0]  ptr_q;
	logic        mack_q;
	logic [7:0]  rd_val;

	// Read multiplexer, used for both serial reads and checks
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			REG_SOFT_RESET:  v[HOLD_BIT] = hold_q;
			REG_DISCH_TIME:  v = {coeff_q, DISCH_RSVD};
			REG_DISCH_STATE: v[DISCH_BIT] = disch_q;
			REG_SRC_STATE:   v[SRC_BIT] = src_q;
			REG_MON_CTRL: begin
				v[OV_OFF_BIT]              = ov_off_q;
				v[WIN_OFF_BIT]             = win_off_q;
				v[SAFE0_LSB+1:SAFE0_LSB]   = safe0_q;
				v[UV_OFF_BIT]              = uv_off_q;
			end
			default:         v = 8'h00;
		endcase
		return v;
	endfunction

	// ========================================================================
	// Bus line events; lines are already in the clock domain
	wire scl_rise  = scl_i & ~scl_q;
	wire scl_fall  = ~scl_i & scl_q;
	wire start_det = scl_i & scl_q & sda_q & ~sda_i;
	wire stop_det  = scl_i & scl_q & ~sda_q & sda_i;
	wire byte_done = (state_q == AG_RX) & scl_fall & (bitcnt_q == 4'd8);
	wire addr_hit  = (shreg_q[7:1] == DEV_ADDR);
	wire wr_data   = byte_done & (byte_idx_q == 2'd2) & ~rw_q;
	always_comb rd_val = reg_read(ptr_q); // A process, so it follows every field it reads

	// Register write strobes; reserved bits are dropped on the floor
	wire wr_hold  = wr_data & (ptr_q == REG_SOFT_RESET);
	wire wr_coeff = wr_data & (ptr_q == REG_DISCH_TIME);
	wire wr_mon   = wr_data & (ptr_q == REG_MON_CTRL);

	// Open drain: only ever pull low, release otherwise
	wire sda_drive = (state_q == AG_ACK) | ((state_q == AG_TX) & ~shreg_q[7]);
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~sda_drive;

	// Line history
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Serial agent sequence; kept alive during hold so software can release it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q    <= AG_IDLE;
			shreg_q    <= 8'h00;
			bitcnt_q   <= 4'd0;
			byte_idx_q <= 2'd0;
			rw_q       <= 1'b0;
			ptr_q      <= 8'h00;
			mack_q     <= 1'b0;
		end else if (start_det) begin
			state_q    <= AG_RX;
			bitcnt_q   <= 4'd0;
			byte_idx_q <= 2'd0;
		end else if (stop_det) begin
			state_q <= AG_IDLE;
		end else begin
			case (state_q)
				AG_RX: begin
					if (scl_rise && bitcnt_q != 4'd8) begin
						shreg_q  <= {shreg_q[6:0], sda_i};
						bitcnt_q <= bitcnt_q + 4'd1;
					end else if (byte_done) begin
						state_q <= (byte_idx_q == 2'd0 && !addr_hit) ? AG_IDLE : AG_ACK;
						if (byte_idx_q == 2'd0) begin
							rw_q <= shreg_q[0];
						end
						if (byte_idx_q == 2'd1 || wr_data) begin
							ptr_q <= (byte_idx_q == 2'd1) ? shreg_q : ptr_q + 8'd1;
						end
					end
				end
				AG_ACK: begin
					if (scl_fall) begin
						bitcnt_q   <= 4'd0;
						byte_idx_q <= (byte_idx_q == 2'd2) ? 2'd2 : byte_idx_q + 2'd1;
						if (rw_q) begin
							state_q <= AG_TX;
							shreg_q <= rd_val;
							ptr_q   <= ptr_q + 8'd1;
						end else begin
							state_q <= AG_RX;
						end
					end
				end
				AG_TX: begin
					if (scl_fall) begin
						shreg_q  <= {shreg_q[6:0], 1'b1};
						bitcnt_q <= bitcnt_q + 4'd1;
						state_q  <= (bitcnt_q == 4'd7) ? AG_MACK : AG_TX;
					end
				end
				AG_MACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_i;
					end else if (scl_fall) begin
						bitcnt_q <= 4'd0;
						if (mack_q) begin
							state_q <= AG_TX;
							shreg_q <= rd_val;
							ptr_q   <= ptr_q + 8'd1;
						end else begin
							state_q <= AG_IDLE;
						end
					end
				end
				default: state_q <= AG_IDLE;
			endcase
		end
	end

	// ========================================================================
	// Control fields: constants at pin reset, memory copy (all but the hold bit) one cycle after
	// release. The hold bit never touches these, so written values survive.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			load_q    <= 1'b1;
			hold_q    <= 1'b0;
			coeff_q   <= COEFF_RST;
			ov_off_q  <= OV_OFF_RST;
			win_off_q <= WIN_OFF_RST;
			safe0_q   <= SAFE0_RST;
			uv_off_q  <= UV_OFF_RST;
		end else begin
			load_q <= 1'b0;
			if (load_q) begin
				coeff_q   <= nvm_i.discharge_time_coeff;
				ov_off_q  <= nvm_i.supply_overvoltage_check_off;
				win_off_q <= nvm_i.bus_window_check_off;
				safe0_q   <= nvm_i.bus_safe_zero_level_sel;
				uv_off_q  <= nvm_i.supply_undervoltage_check_off;
			end
			if (wr_hold) begin
				hold_q <= shreg_q[HOLD_BIT];
			end
			if (wr_coeff) begin
				coeff_q <= shreg_q[COEFF_LSB+3:COEFF_LSB];
			end
			if (wr_mon) begin
				ov_off_q  <= shreg_q[OV_OFF_BIT];
				win_off_q <= shreg_q[WIN_OFF_BIT];
				safe0_q   <= shreg_q[SAFE0_LSB+1:SAFE0_LSB];
				uv_off_q  <= shreg_q[UV_OFF_BIT];
			end
		end
	end

	// ========================================================================
	// Monitoring and gating; comparators come from bus sense side except the
	// supply pair, which watches the main supply
	wire bus_ok = win_off_q ? cmp_q.bus_above_uvlo : cmp_q.bus_in_window;
	wire uv_ok  = uv_off_q | cmp_q.supply_above_uvlo;
	wire ov_ok  = ov_off_q | cmp_q.supply_below_ovlo;
	wire src_d  = attach_req_i & bus_ok & uv_ok & ov_ok & ~disch_q;
	wire tick   = (unit_q == UNIT_CNT_W'(UNIT_CYC - 1));

	assign core_hold_o               = hold_q;
	assign bus_safe_zero_level_sel_o = safe0_q;
	assign bus_valid_o               = bus_ok;
	assign attach_safe0_ok_o         = cmp_q.bus_below_safe0;
	assign discharge_active_flag_o   = disch_q;
	assign source_path_enable_pin_o  = src_q;

	// Comparator capture; analog edges are only seen a cycle late, harmless
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmp_q <= '0;
		end else begin
			cmp_q <= cmp_i;
		end
	end

	// Source path and discharge timer, both cleared while the hold bit is set
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			src_q   <= 1'b0;
			disch_q <= 1'b0;
			unit_q  <= '0;
			left_q  <= 4'd0;
		end else if (hold_q) begin
			src_q   <= 1'b0;
			disch_q <= 1'b0;
			unit_q  <= '0;
			left_q  <= 4'd0;
		end else begin
			src_q <= src_d;
			if (discharge_start_i && !disch_q) begin
				disch_q <= (coeff_q != 4'd0);
				left_q  <= coeff_q;
				unit_q  <= '0;
			end else if (disch_q) begin
				unit_q <= tick ? '0 : unit_q + UNIT_CNT_W'(1);
				if (tick) begin
					left_q <= left_q - 4'd1;
					if (left_q == 4'd1) begin
						disch_q <= 1'b0;
					end
				end
			end
		end
	end

	// ========================================================================
	// Checks
	sequence s_disch_start;
		discharge_start_i && !disch_q && !hold_q && coeff_q != 4'd0;
	endsequence

	sequence s_disch_runs;
		disch_q [*3];
	endsequence

	chk_hold_kills_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		hold_q |=> !src_q && !disch_q)
		else $error("source or discharge active under hold");
	chk_disch_starts: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_disch_start |=> s_disch_runs)
		else $error("discharge did not start and run");
	chk_disch_end_ok: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$fell(disch_q) && !$past(hold_q) |-> $past(tick) && $past(left_q) == 4'd1)
		else $error("discharge ended before its count");
	chk_disch_flag_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ptr_q == REG_DISCH_STATE |-> rd_val == {disch_q, 7'h00})
		else $error("discharge status read mismatch");
	chk_src_flag_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ptr_q == REG_SRC_STATE |-> rd_val == {7'h00, src_q})
		else $error("source status read mismatch");
	chk_uv_gates_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!uv_off_q && !cmp_q.supply_above_uvlo |=> !src_q)
		else $error("source on with supply under-voltage");
	chk_ov_gates_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!ov_off_q && !cmp_q.supply_below_ovlo |=> !src_q)
		else $error("source on with supply over-voltage");
	chk_bus_sel_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		src_q |-> ($past(win_off_q) ? $past(cmp_q.bus_above_uvlo) : $past(cmp_q.bus_in_window)))
		else $error("source on without selected bus condition");
	chk_cmp_registered: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) |-> attach_safe0_ok_o == $past(cmp_i.bus_below_safe0))
		else $error("safe-zero result not registered");
	chk_nvm_loaded: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		load_q && !wr_coeff |=> coeff_q == $past(nvm_i.discharge_time_coeff))
		else $error("memory default not loaded");

endmodule

/* File: hdl/bppm_pkg.sv */
// Package: register map, field layout, reset values and timing for the bus power path monitor
package bppm_pkg;

	// ========================================================================
	// Register offsets (8-bit register pointer)
	localparam logic [7:0] REG_SOFT_RESET  = 8'h23;
	localparam logic [7:0] REG_DISCH_TIME  = 8'h25;
	localparam logic [7:0] REG_DISCH_STATE = 8'h26;
	localparam logic [7:0] REG_SRC_STATE   = 8'h27;
	localparam logic [7:0] REG_MON_CTRL    = 8'h2E;

	// ========================================================================
	// Field positions
	localparam int HOLD_BIT     = 0;
	localparam int COEFF_LSB    = 4;
	localparam int DISCH_BIT    = 7;
	localparam int SRC_BIT      = 0;
	localparam int OV_OFF_BIT   = 6;
	localparam int WIN_OFF_BIT  = 4;
	localparam int SAFE0_LSB    = 1;
	localparam int UV_OFF_BIT   = 0;

	// ========================================================================
	// Reset values, before the nonvolatile copy lands
	localparam logic [3:0] COEFF_RST    = 4'h6;
	localparam logic [3:0] DISCH_RSVD   = 4'hF;
	localparam logic       OV_OFF_RST   = 1'b0;
	localparam logic       WIN_OFF_RST  = 1'b0;
	localparam logic [1:0] SAFE0_RST    = 2'h0;
	localparam logic       UV_OFF_RST   = 1'b1;

	// Safe-zero select codes: 0.6 V, 0.9 V, 1.2 V, 1.8 V
	localparam logic [1:0] SAFE0_0V6 = 2'h0;
	localparam logic [1:0] SAFE0_0V9 = 2'h1;
	localparam logic [1:0] SAFE0_1V2 = 2'h2;
	localparam logic [1:0] SAFE0_1V8 = 2'h3;

	// ========================================================================
	// Timing
	localparam int CLK_HZ        = 50_000_000;
	localparam int DISCH_UNIT_MS = 84;
	localparam int DISCH_UNIT_CYC = DISCH_UNIT_MS * (CLK_HZ / 1000);
	localparam int UNIT_CNT_W    = 23;

	// Bus agent address: value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEF = 7'h28;

	// ========================================================================
	// Comparator results from the analog front end
	typedef struct packed {
		logic bus_in_window;
		logic bus_above_uvlo;
		logic bus_below_safe0;
		logic supply_above_uvlo;
		logic supply_below_ovlo;
	} bppm_cmp_t;

	// Nonvolatile defaults presented by the memory
	typedef struct packed {
		logic [3:0] discharge_time_coeff;
		logic       supply_overvoltage_check_off;
		logic       bus_window_check_off;
		logic [1:0] bus_safe_zero_level_sel;
		logic       supply_undervoltage_check_off;
	} bppm_nvm_t;

	// Serial agent states
	typedef enum logic [4:0] {
		AG_IDLE = 5'b00001,
		AG_RX   = 5'b00010,
		AG_ACK  = 5'b00100,
		AG_TX   = 5'b01000,
		AG_MACK = 5'b10000
	} bppm_state_t;

endpackage

/* File: sim/bppm_host_model.sv */
// Host microcontroller model driving the serial register port of the monitor
`timescale 1ns/1ps
module bppm_host_model
	import bppm_pkg::*;
(
	// Clock and resolved data wire
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Lines driven by the host, data open drain
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	// ========================================================================
	// Bus idle: clock driven high, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	// Phases of 4 clocks keep well clear of the 3-clock minimum
	task automatic tick();
		repeat (4) @(posedge clk_i);
		#1;
	endtask

	// Data only moves while the clock line is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		tick();
		sda_oe_n_o = b;
		tick();
		scl_o = 1'b1;
		tick();
		r = sda_i;
		scl_o = 1'b0;
	endtask

	// Start, also used as repeated start
	task automatic start();
		tick();
		sda_oe_n_o = 1'b1;
		tick();
		scl_o = 1'b1;
		tick();
		sda_oe_n_o = 1'b0;
		tick();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		tick();
		sda_oe_n_o = 1'b0;
		tick();
		scl_o = 1'b1;
		tick();
		sda_oe_n_o = 1'b1;
	endtask

	// ========================================================================
	// One byte, MSB first, plus the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
		output logic ao);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ai, ao);
	endtask

	// Pointer then one data byte; ok is low if any byte went unacknowledged
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2;
		start();
		xfer({dev, 1'b0}, 1'b1, rx, a0);
		xfer(ptr, 1'b1, rx, a1);
		xfer(d, 1'b1, rx, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask

	// Pointer write, repeated start, one byte read closed by a NACK
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
		logic [7:0] rx;
		logic       a;
		start();
		xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, rx, a);
		xfer(ptr, 1'b1, rx, a);
		start();
		xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, rx, a);
		xfer(8'hFF, 1'b1, d, a);
		stop();
	endtask

	// Two-byte read: the first byte is acknowledged, so the agent goes on to the next
	task automatic read_pair(input logic [7:0] ptr, output logic [7:0] d0,
		output logic [7:0] d1);
		logic [7:0] rx;
		logic       a;
		start();
		xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, rx, a);
		xfer(ptr, 1'b1, rx, a);
		start();
		xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, rx, a);
		xfer(8'hFF, 1'b0, d0, a);
		xfer(8'hFF, 1'b1, d1, a);
		stop();
	endtask
endmodule

/* File: sim/test_bus_power_path_monitor_regs.sv */
// Self-checking bench for the bus power path monitor registers
`timescale 1ns/1ps
module test_bus_power_path_monitor_regs
	import bppm_pkg::*;
;
	// ========================================================================
	// Signals; short discharge unit keeps the run brief
	localparam int UNIT = 200;
	localparam logic [7:0] G_CTRL [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h40, 8'h00, 8'h10, 8'h10};
	localparam logic [4:0] G_CMP [8] = '{5'h1F, 5'h1D, 5'h1D, 5'h1E, 5'h1E, 5'h0B, 5'h0B, 5'h17};
	localparam logic [7:0] G_SRC = 8'h55;
	localparam logic [7:0] G_VAL = 8'h5F;
	logic       clk, arst_n, scl, sda, host_oe_n, dut_oe_n, dut_sda;
	logic       attach, dstart, hold, safe_ok, bvalid, dflag, src, ok;
	logic [1:0] s0sel;
	logic [7:0] rd, rd2;
	bppm_nvm_t  nvm;
	bppm_cmp_t  cmp;
	int         fails, checks, n;

	// Open-drain wire with pull-up
	assign sda = host_oe_n & (dut_oe_n | dut_sda);

	bppm_regs #(.UNIT_CYC(UNIT), .DEV_ADDR(DEV_ADDR_DEF)) DUT (
		.clk_i                    (clk),
		.arst_n_i                 (arst_n),
		.scl_i                    (scl),
		.sda_i                    (sda),
		.sda_o                    (dut_sda),
		.sda_oe_n_o               (dut_oe_n),
		.nvm_i                    (nvm),
		.cmp_i                    (cmp),
		.attach_req_i             (attach),
		.discharge_start_i        (dstart),
		.core_hold_o              (hold),
		.bus_safe_zero_level_sel_o(s0sel),
		.bus_valid_o              (bvalid),
		.attach_safe0_ok_o        (safe_ok),
		.discharge_active_flag_o  (dflag),
		.source_path_enable_pin_o (src)
	);

	bppm_host_model HOST (
		.clk_i     (clk),
		.sda_i     (sda),
		.scl_o     (scl),
		.sda_oe_n_o(host_oe_n)
	);

	// ========================================================================
	// Clock and watchdog; the tests need about 23k cycles
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#1_600_000;
		fails++;
		complete_run();
	end

	// ========================================================================
	// Helpers
	task automatic cmpv(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		HOST.write_reg(DEV_ADDR_DEF, p, d, ok);
		cmpv(ok, 1'b1);
	endtask

	task automatic rdc(input logic [7:0] p, input logic [7:0] e);
		HOST.read_reg(p, rd);
		cmpv(rd, e);
	endtask

	task automatic pin_reset();
		arst_n = 1'b0;
		cyc(6);
		arst_n = 1'b1;
		cyc(3);
	endtask

	task automatic pulse();
		dstart = 1'b1;
		cyc(1);
		dstart = 1'b0;
	endtask

	task automatic end_test(input string name);
		$display("Test %s done: checks %0d fails %0d", name, checks, fails);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ========================================================================
	// Tests
	initial begin
		arst_n = 1'b0;
		nvm = 9'h13C;
		cmp = 5'h1F;
		attach = 1'b1;
		dstart = 1'b0;
		pin_reset();
		// Foreign device address is not acknowledged
		HOST.write_reg(DEV_ADDR_DEF ^ 7'h01, REG_SOFT_RESET, 8'h00, ok);
		cmpv(ok, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(REG_MON_CTRL, 8'(i * 2));
			cmpv(s0sel, i);
			rdc(REG_MON_CTRL, 8'(i * 2));
		end
		end_test("safe_zero");
		// After the all-pass first entry, each entry breaks or restores one gating condition
		for (int i = 0; i < 8; i++) begin
			cmp = G_CMP[i];
			wr(REG_MON_CTRL, G_CTRL[i]);
			cyc(4);
			cmpv(src, G_SRC[i]);
			cmpv(bvalid, G_VAL[i]);
			cmpv(safe_ok, G_CMP[i][2]);
			rdc(REG_SRC_STATE, {7'h00, G_SRC[i]});
		end
		end_test("gating");
		cmp = 5'h1F;
		wr(REG_MON_CTRL, 8'h44);
		wr(REG_SOFT_RESET, 8'h01);
		cyc(4);
		cmpv(hold, 1'b1);
		cmpv(src, 1'b0);
		rdc(REG_MON_CTRL, 8'h44);
		rdc(REG_SOFT_RESET, 8'h01);
		wr(REG_SOFT_RESET, 8'h00);
		cyc(4);
		cmpv(hold, 1'b0);
		cmpv(src, 1'b1);
		wr(8'h24, 8'hFF);
		wr(REG_SRC_STATE, 8'hFF);
		rdc(REG_SOFT_RESET, 8'h00);
		rdc(REG_SRC_STATE, 8'h01);
		end_test("soft_hold");
		// Discharge length is counted cycle by cycle
		wr(REG_DISCH_TIME, 8'h20);
		pulse();
		n = 0;
		repeat (3 * UNIT) begin
			if (dflag === 1'b1) n++;
			cyc(1);
		end
		cmpv(n, 2 * UNIT);
		wr(REG_DISCH_TIME, 8'h00);
		pulse();
		cyc(2);
		cmpv(dflag, 1'b0);
		wr(REG_DISCH_TIME, 8'hF0);
		rdc(REG_DISCH_TIME, 8'hFF);
		pulse();
		rdc(REG_DISCH_STATE, 8'h80);
		cmpv(src, 1'b0);
		// Burst read walks the pointer from discharge state into source state
		HOST.read_pair(REG_DISCH_STATE, rd, rd2);
		cmpv(rd, 8'h80);
		cmpv(rd2, 8'h00);
		for (int k = 0; k < 20 * UNIT && dflag === 1'b1; k++) cyc(1);
		rdc(REG_DISCH_STATE, 8'h00);
		cmpv(src, 1'b1);
		end_test("discharge");
		// Second pin reset shows the memory copy, not the written values
		for (int j = 0; j < 2; j++) begin
			nvm = j ? 9'h0C1 : 9'h13C;
			pin_reset();
			rdc(REG_DISCH_TIME, j ? 8'h6F : 8'h9F);
			rdc(REG_MON_CTRL, j ? 8'h01 : 8'h54);
			rdc(REG_SOFT_RESET, 8'h00);
			rdc(REG_DISCH_STATE, 8'h00);
			cmpv(s0sel, j ? 2'h0 : 2'h2);
		end
		end_test("reset_defaults");
		complete_run();
	end
endmodule
